// ### inc/ras_pkg.sv
// package for the return address stack: register map, field layout, widths
// assumes a single core clock domain and a plain strobe register port
package ras_pkg;
    localparam int RAS_LEVEL_W = 5;
    localparam int RAS_PC_W = 21;
    localparam logic [RAS_LEVEL_W-1:0] RAS_LEVEL_MAX = 5'h1F;
    localparam logic [RAS_LEVEL_W-1:0] RAS_LEVEL_ZERO = 5'h00;
    localparam logic [RAS_PC_W-1:0] RAS_PC_STEP = 21'h000002;
    localparam int RAS_ADDR_W = 3;
    localparam logic [RAS_ADDR_W-1:0] RAS_REG_STACK_PTR = 3'h0;
    localparam logic [RAS_ADDR_W-1:0] RAS_REG_TOP_LOW = 3'h1;
    localparam logic [RAS_ADDR_W-1:0] RAS_REG_TOP_HIGH = 3'h2;
    localparam logic [RAS_ADDR_W-1:0] RAS_REG_TOP_UPPER = 3'h3;
    localparam logic [RAS_ADDR_W-1:0] RAS_REG_IRQ_STATUS = 3'h4;
    localparam logic [RAS_ADDR_W-1:0] RAS_REG_IRQ_MASK = 3'h5;
    localparam int RAS_BIT_FULL = 7;
    localparam int RAS_BIT_UNF = 6;
    localparam int RAS_IRQ_W = 2;
    localparam int RAS_IRQ_FULL = 1;
    localparam int RAS_IRQ_UNF = 0;
    localparam logic [7:0] RAS_BYTE_ZERO = 8'h00;
    typedef struct packed {
        logic push;
        logic pop;
        logic [RAS_PC_W-1:0] pc;
    } ras_core_req_t;
    typedef enum logic [1:0] {
        RAS_ST_RUN = 2'b00,
        RAS_ST_OVF_RESET = 2'b01
    } ras_state_t;
endpackage : ras_pkg

// ### verilog/ras_return_stack.sv
// return address stack: 31 entries, level pointer, full/underflow flags
// assumes push and pop from the sequencer are one-cycle pulses, never together
// Behaviour
// - stack level ranges from 0 to 31
// - push increments level then stores; pop reads then decrements
// - any reset sets stack level to zero; the por input does not, it only clears the flags
// - software reads and writes stack level through stack pointer register
// - full flag sets after 31 pushes without a pop
// - full flag clears only by software or power-on reset
// - overflow reset enabled: 31st push stores pc plus two, sets full, resets
// - after overflow reset full flag stays set, level forced to zero
// - overflow reset disabled: 31st push sets full, level becomes 31
// - with overflow reset disabled further pushes ignored, level held 31
// - pop on empty stack returns zero, sets underflow, level stays zero
// - underflow flag stays set until software clear or power-on reset
// - underflow only redirects to zero; not a reset, registers untouched
// - top entry readable and writable via upper, high and low byte registers
// - software push increments level and stores current pc in new top; the register port has no push command, only the core can push
// - software pop discards top by decrementing level; no pop command exists, software writes a lower level to the stack pointer
// - full flag bit 7, underflow bit 6, clear-only, reset zero
// - level in bits 4..0, bit 5 reads zero
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module ras_return_stack #(
    parameter int DEPTH = 31
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic por,
    input wire logic clk_en,
    input wire logic overflow_reset_enable,
    input wire ras_pkg::ras_core_req_t core_req,
    input wire logic [ras_pkg::RAS_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic [ras_pkg::RAS_PC_W-1:0] pop_pc,
    output logic pop_valid,
    output logic device_reset_req,
    output logic irq
);
    logic [ras_pkg::RAS_PC_W-1:0] entry [1:DEPTH];
    logic [ras_pkg::RAS_LEVEL_W-1:0] stack_level;
    logic stack_full_flag;
    logic stack_underflow_flag;
    logic [ras_pkg::RAS_IRQ_W-1:0] irq_status;
    logic [ras_pkg::RAS_IRQ_W-1:0] irq_mask;
    ras_pkg::ras_state_t state;

    wire running = (state == ras_pkg::RAS_ST_RUN);
    wire at_top = (stack_level == ras_pkg::RAS_LEVEL_MAX);
    wire is_empty = (stack_level == ras_pkg::RAS_LEVEL_ZERO);
    wire last_slot = (stack_level == ras_pkg::RAS_LEVEL_MAX - 5'h01);
    wire do_push = clk_en && running && core_req.push && !at_top;
    wire do_pop = clk_en && running && core_req.pop && !core_req.push;
    wire push_fills = do_push && last_slot;
    wire ovf_reset = push_fills && overflow_reset_enable;
    wire pop_unf = do_pop && is_empty;
    wire [ras_pkg::RAS_LEVEL_W-1:0] level_up = stack_level + 5'h01;
    wire [ras_pkg::RAS_PC_W-1:0] push_value = ovf_reset ? core_req.pc + ras_pkg::RAS_PC_STEP : core_req.pc;
    wire sel_sp = (reg_addr == ras_pkg::RAS_REG_STACK_PTR);
    wire sel_lo = (reg_addr == ras_pkg::RAS_REG_TOP_LOW);
    wire sel_hi = (reg_addr == ras_pkg::RAS_REG_TOP_HIGH);
    wire sel_up = (reg_addr == ras_pkg::RAS_REG_TOP_UPPER);
    wire sel_ist = (reg_addr == ras_pkg::RAS_REG_IRQ_STATUS);
    wire sel_imk = (reg_addr == ras_pkg::RAS_REG_IRQ_MASK);
    wire wr_sp = clk_en && reg_write && sel_sp;
    wire wr_lo = clk_en && reg_write && sel_lo;
    wire wr_hi = clk_en && reg_write && sel_hi;
    wire wr_up = clk_en && reg_write && sel_up;
    wire wr_ist = clk_en && reg_write && sel_ist;
    wire wr_imk = clk_en && reg_write && sel_imk;
    wire [ras_pkg::RAS_PC_W-1:0] top_value = is_empty ? '0 : entry[stack_level];
    // writing zero clears, writing one keeps; a set in the same cycle wins
    wire next_full = push_fills | (stack_full_flag & ~(wr_sp & ~reg_wdata[ras_pkg::RAS_BIT_FULL]));
    wire next_unf = pop_unf | (stack_underflow_flag & ~(wr_sp & ~reg_wdata[ras_pkg::RAS_BIT_UNF]));
    wire [ras_pkg::RAS_IRQ_W-1:0] irq_set = {push_fills, pop_unf};
    wire [ras_pkg::RAS_IRQ_W-1:0] next_irq_status = irq_set | (irq_status & ~({ras_pkg::RAS_IRQ_W{wr_ist}} &
        reg_wdata[ras_pkg::RAS_IRQ_W-1:0]));
    wire [ras_pkg::RAS_PC_W-1:0] pc_bytes_lo = {top_value[20:8], reg_wdata};
    wire [ras_pkg::RAS_PC_W-1:0] pc_bytes_hi = {top_value[20:16], reg_wdata, top_value[7:0]};
    wire [ras_pkg::RAS_PC_W-1:0] pc_bytes_up = {reg_wdata[4:0], top_value[15:0]};
    wire [7:0] sp_view = {stack_full_flag, stack_underflow_flag, 1'b0, stack_level};
    wire [7:0] next_rdata = sel_sp ? sp_view :
        sel_lo ? top_value[7:0] :
        sel_hi ? top_value[15:8] :
        sel_up ? {3'h0, top_value[20:16]} :
        sel_ist ? {6'h00, irq_status} :
        sel_imk ? {6'h00, irq_mask} : ras_pkg::RAS_BYTE_ZERO;

    // stack level: the overflow-reset state holds it at zero for one cycle unless software writes the stack pointer
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            stack_level <= ras_pkg::RAS_LEVEL_ZERO;
        else if (clk_en)
        begin
            if (ovf_reset)
                stack_level <= ras_pkg::RAS_LEVEL_ZERO;
            else if (do_push)
                stack_level <= level_up;
            else if (do_pop && !is_empty)
                stack_level <= stack_level - 5'h01;
            else if (wr_sp)
                stack_level <= reg_wdata[ras_pkg::RAS_LEVEL_W-1:0];
        end
    end

    // entries are plain storage, not reset: contents survive an underflow
    genvar gi;
    generate
        for (gi = 1; gi <= DEPTH; gi++)
        begin : g_entry
            wire here = (stack_level == ras_pkg::RAS_LEVEL_W'(gi));
            wire push_here = do_push && (level_up == ras_pkg::RAS_LEVEL_W'(gi));
            always_ff @(posedge clk_sys)
            begin
                if (push_here)
                    entry[gi] <= push_value;
                else if (here && wr_lo)
                    entry[gi] <= pc_bytes_lo;
                else if (here && wr_hi)
                    entry[gi] <= pc_bytes_hi;
                else if (here && wr_up)
                    entry[gi] <= pc_bytes_up;
            end
        end
    endgenerate

    // flags survive the device reset; only por or a software write of zero clears them
    always_ff @(posedge clk_sys or posedge por)
    begin
        if (por)
        begin
            stack_full_flag <= 1'b0;
            stack_underflow_flag <= 1'b0;
        end
        else if (clk_en)
        begin
            stack_full_flag <= next_full;
            stack_underflow_flag <= next_unf;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
            state <= ras_pkg::RAS_ST_RUN;
        else if (clk_en)
        begin
            case (state)
                ras_pkg::RAS_ST_RUN:
                    state <= ovf_reset ? ras_pkg::RAS_ST_OVF_RESET : ras_pkg::RAS_ST_RUN;
                ras_pkg::RAS_ST_OVF_RESET:
                    state <= ras_pkg::RAS_ST_RUN;
                default:
                    state <= ras_pkg::RAS_ST_RUN;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pop_pc <= '0;
            pop_valid <= 1'b0;
            device_reset_req <= 1'b0;
            reg_rdata <= ras_pkg::RAS_BYTE_ZERO;
            irq_status <= '0;
            irq_mask <= '0;
            irq <= 1'b0;
        end
        else if (clk_en)
        begin
            pop_pc <= do_pop ? top_value : pop_pc;
            pop_valid <= do_pop;
            device_reset_req <= ovf_reset;
            reg_rdata <= reg_read ? next_rdata : ras_pkg::RAS_BYTE_ZERO;
            irq_status <= next_irq_status;
            irq_mask <= wr_imk ? reg_wdata[ras_pkg::RAS_IRQ_W-1:0] : irq_mask;
            irq <= |(next_irq_status & (wr_imk ? reg_wdata[ras_pkg::RAS_IRQ_W-1:0] : irq_mask));
        end
    end

    level_range_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (clk_en && at_top && !core_req.pop && !wr_sp)
        |=> at_top
    ) else $error("stack level left its ceiling");

    push_inc_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (do_push && !ovf_reset)
        |=> stack_level == $past(stack_level) + 5'h01
    ) else $error("push did not step");

    pop_dec_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (do_pop && !is_empty)
        |=> stack_level == $past(stack_level) - 5'h01
    ) else $error("pop did not step");

    freeze_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        !clk_en
        |=> stack_level == $past(stack_level) && state == $past(state)
    ) else $error("state moved while frozen");

    reset_level_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        $past(reset)
        |-> stack_level == ras_pkg::RAS_LEVEL_ZERO
    ) else $error("level not zero after reset");

    sp_write_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (wr_sp && !do_push && !do_pop)
        |=> stack_level == $past(reg_wdata[ras_pkg::RAS_LEVEL_W-1:0])
    ) else $error("level write lost");

    sp_read_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (clk_en && reg_read && sel_sp)
        |=> reg_rdata[ras_pkg::RAS_LEVEL_W-1:0] == $past(stack_level)
    ) else $error("level read wrong");

    full_sets_a: assert property (
        @(posedge clk_sys) disable iff (reset || por)
        push_fills
        |=> stack_full_flag
    ) else $error("full flag not set");

    full_stick_a: assert property (
        @(posedge clk_sys) disable iff (reset || por)
        (stack_full_flag && !wr_sp)
        |=> stack_full_flag
    ) else $error("full flag dropped");

    full_clear_a: assert property (
        @(posedge clk_sys) disable iff (reset || por)
        (wr_sp && !reg_wdata[ras_pkg::RAS_BIT_FULL] && !push_fills)
        |=> !stack_full_flag
    ) else $error("full flag not cleared");

    ovf_entry_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        ovf_reset
        |=> entry[DEPTH] == $past(core_req.pc) + ras_pkg::RAS_PC_STEP
    ) else $error("overflow entry wrong");

    ovf_reset_a: assert property (
        @(posedge clk_sys) disable iff (reset || por)
        ovf_reset
        |=> device_reset_req && stack_level == ras_pkg::RAS_LEVEL_ZERO && stack_full_flag
    ) else $error("overflow reset wrong");

    ovf_hold_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        ovf_reset
        |=> !running
    ) else $error("overflow state missed");

    sat_full_a: assert property (
        @(posedge clk_sys) disable iff (reset || por)
        (push_fills && !overflow_reset_enable)
        |=> at_top && stack_full_flag && !device_reset_req
    ) else $error("saturating fill wrong");

    sat_hold_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (clk_en && at_top && core_req.push && !wr_sp)
        |=> at_top
    ) else $error("level left 31");

    sat_entry_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (clk_en && at_top && core_req.push && !reg_write)
        |=> entry[DEPTH] == $past(entry[DEPTH])
    ) else $error("saturated entry overwritten");

    underflow_a: assert property (
        @(posedge clk_sys) disable iff (reset || por)
        pop_unf
        |=> pop_valid && pop_pc == '0 && stack_underflow_flag && is_empty
    ) else $error("underflow handling wrong");

    unf_stick_a: assert property (
        @(posedge clk_sys) disable iff (reset || por)
        (stack_underflow_flag && !wr_sp)
        |=> stack_underflow_flag
    ) else $error("underflow flag dropped");

    unf_clear_a: assert property (
        @(posedge clk_sys) disable iff (reset || por)
        (wr_sp && !reg_wdata[ras_pkg::RAS_BIT_UNF] && !pop_unf)
        |=> !stack_underflow_flag
    ) else $error("underflow flag not cleared");

    unf_no_reset_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        pop_unf
        |=> !device_reset_req
    ) else $error("underflow reset device");

    unf_regs_a: assert property (
        @(posedge clk_sys) disable iff (reset || por)
        (pop_unf && !reg_write)
        |=> irq_mask == $past(irq_mask) && stack_full_flag == $past(stack_full_flag)
    ) else $error("underflow touched registers");

    top_low_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (clk_en && reg_read && sel_lo)
        |=> reg_rdata == $past(top_value[7:0])
    ) else $error("top low byte read wrong");

    top_write_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (wr_lo && !is_empty && !do_push && !do_pop)
        |=> top_value[7:0] == $past(reg_wdata)
    ) else $error("top low byte write lost");

    push_store_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (do_push && !ovf_reset)
        |=> top_value == $past(core_req.pc)
    ) else $error("pushed pc not on top");

    pop_out_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (do_pop && !is_empty)
        |=> pop_valid && pop_pc == $past(top_value)
    ) else $error("popped value wrong");

    flag_bits_a: assert property (
        @(posedge clk_sys) disable iff (reset || por)
        (clk_en && reg_read && sel_sp)
        |=> reg_rdata[ras_pkg::RAS_BIT_FULL] == $past(stack_full_flag) && reg_rdata[ras_pkg::RAS_BIT_UNF] == $past(stack_underflow_flag)
    ) else $error("flag bits misplaced");

    bit5_zero_a: assert property (
        @(posedge clk_sys) disable iff (reset)
        (clk_en && reg_read && sel_sp)
        |=> !reg_rdata[5]
    ) else $error("bit 5 set");

    flag_one_a: assert property (
        @(posedge clk_sys) disable iff (reset || por)
        (stack_full_flag && wr_sp && reg_wdata[ras_pkg::RAS_BIT_FULL])
        |=> stack_full_flag
    ) else $error("flag cleared by one");

    unf_one_a: assert property (
        @(posedge clk_sys) disable iff (reset || por)
        (stack_underflow_flag && wr_sp && reg_wdata[ras_pkg::RAS_BIT_UNF])
        |=> stack_underflow_flag
    ) else $error("underflow flag cleared by one");

    fill_c: cover property (
        @(posedge clk_sys) disable iff (reset)
        push_fills);

    ovf_c: cover property (
        @(posedge clk_sys) disable iff (reset)
        ovf_reset);

    sat_c: cover property (
        @(posedge clk_sys) disable iff (reset)
        clk_en && at_top && core_req.push && !overflow_reset_enable);

    unf_c: cover property (
        @(posedge clk_sys) disable iff (reset)
        pop_unf);

    irq_c: cover property (
        @(posedge clk_sys) disable iff (reset)
        irq);
endmodule : ras_return_stack
`default_nettype wire

// ### verification/ras_core_model.sv
// core sequencer model: issues call and return pulses to the stack
// assumes one caller at a time; each request lasts exactly one cycle
`timescale 1ns/100ps
`default_nettype none
module ras_core_model (
    input wire logic clk_sys,
    output var ras_pkg::ras_core_req_t core_req
);
    initial core_req = '0;
    task automatic push(input logic [20:0] pc);
        @(posedge clk_sys);
        core_req <= '{push: 1'b1, pop: 1'b0, pc: pc};
        @(posedge clk_sys);
        // idle pc shows the inverse so a late capture cannot pass
        core_req <= '{push: 1'b0, pop: 1'b0, pc: ~pc};
    endtask : push
    task automatic pop();
        @(posedge clk_sys);
        core_req.pop <= 1'b1;
        @(posedge clk_sys);
        core_req.pop <= 1'b0;
    endtask : pop
endmodule : ras_core_model
`default_nettype wire

// ### verification/return_address_stack_bench.sv
// bench for the return address stack: register tasks plus core model
// assumes one clock, reset and power-on reset raised together at start
`timescale 1ns/100ps
`default_nettype none
module return_address_stack_bench;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic por = 1'b1;
    logic ovf_en = 1'b0;
    logic clk_en = 1'b1;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, rd;
    logic [20:0] pop_pc, top;
    logic pop_valid, rst_req, irq;
    logic rst_seen = 1'b0;
    ras_pkg::ras_core_req_t core_req;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    ras_core_model core (.clk_sys(clk_sys), .core_req(core_req));
    ras_return_stack dut (.clk_sys(clk_sys), .reset(reset), .por(por), .clk_en(clk_en),
        .overflow_reset_enable(ovf_en), .core_req(core_req), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .pop_pc(pop_pc), .pop_valid(pop_valid),
        .device_reset_req(rst_req), .irq(irq));
    initial forever #2 clk_sys = ~clk_sys;
    // ceiling well above the roughly 210 cycles the sequence needs
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (rst_req === 1'b1)
            rst_seen <= 1'b1;
        if (cycles == 4000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end
    function automatic logic [20:0] pcv(input int i);
        return {16'hA5C3, i[4:0]};
    endfunction : pcv
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [2:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 rd = reg_rdata;
    endtask : rdr
    task automatic rd_top();
        rdr(3'h3);
        top[20:16] = rd[4:0];
        rdr(3'h2);
        top[15:8] = rd;
        rdr(3'h1);
        top[7:0] = rd;
    endtask : rd_top
    task automatic end_of_test();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        por <= 1'b0;
        rdr(3'h0);
        check("sp after reset", rd, 8'h00);
        @(posedge clk_sys);
        clk_en <= 1'b0;
        core.push(pcv(9));
        clk_en <= 1'b1;
        rdr(3'h0);
        check("frozen sp", rd, 8'h00);
        for (int i = 1; i <= 3; i++)
            core.push(pcv(i));
        rdr(3'h0);
        check("sp level", rd, 8'h03);
        rd_top();
        check("top entry", top, pcv(3));
        core.pop();
        #1 check("pop value", {pop_valid, pop_pc}, {1'b1, pcv(3)});
        wr(3'h1, 8'h5A);
        core.pop();
        top = pcv(2);
        #1 check("edited top", pop_pc, {top[20:8], 8'h5A});
        wr(3'h0, 8'hFF);
        rdr(3'h0);
        check("sp write", rd, 8'h1F);
        wr(3'h0, 8'h00);
        core.pop();
        #1 check("underflow pc", pop_pc, 21'h000000);
        rdr(3'h0);
        check("underflow sp", rd, 8'h40);
        wr(3'h5, 8'h01);
        repeat (2) @(posedge clk_sys);
        #1 check("irq on", irq, 1'b1);
        wr(3'h4, 8'h01);
        repeat (2) @(posedge clk_sys);
        #1 check("irq off", irq, 1'b0);
        wr(3'h0, 8'h40);
        rdr(3'h0);
        check("flag kept", rd, 8'h40);
        wr(3'h0, 8'h00);
        for (int i = 1; i <= 32; i++)
            core.push(pcv(i));
        rdr(3'h0);
        check("saturated sp", rd, 8'h9F);
        rd_top();
        check("31st entry", {rst_seen, top}, {1'b0, pcv(31)});
        wr(3'h0, 8'h00);
        ovf_en <= 1'b1;
        for (int i = 1; i <= 31; i++)
            core.push(pcv(i));
        rdr(3'h0);
        check("overflow sp", {rst_seen, rd}, 9'h180);
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        rdr(3'h0);
        check("full after reset", rd, 8'h80);
        wr(3'h0, 8'h9F);
        rd_top();
        check("pc plus two", top, pcv(31) + 21'h000002);
        end_of_test();
    end
endmodule : return_address_stack_bench
`default_nettype wire
